//--- hdl/bcf_codebook_feedback.sv
`timescale 1ns/1ps
`default_nettype none

module bcf_codebook_feedback (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Codebook request
  input wire logic cb_start,
  input wire bcf_pkg::bcf_book_e cb_book,
  input wire logic [5:0] cfg_ant_count,
  // Codebook element stream
  output logic cb_valid,
  output logic [5:0] cb_row,
  output logic [6:0] cb_col,
  output logic [6:0] cb_modulus,
  output logic [6:0] cb_phase,
  output logic cb_neg,
  output logic cb_last,
  output logic cb_busy,
  output logic cfg_err,
  // Estimated weight phases
  input wire logic wt_valid,
  input wire logic signed [13:0] wt_phase,
  // Feedback octets
  output logic fb_valid,
  output logic [7:0] fb_octet,
  output logic [5:0] fb_comp,
  output logic fb_last,
  output logic fb_range_err
);
  import bcf_pkg::*;

  bcf_state_e state, next_state;
  bcf_book_e book, next_book;
  logic [5:0] nant, next_nant;
  logic [2:0] set_idx, next_set_idx;
  logic [6:0] modulus, next_modulus;
  logic [6:0] last_col, next_last_col;
  logic [5:0] row, next_row;
  logic [6:0] col, next_col;
  logic [6:0] acc, next_acc;
  logic next_cb_valid, next_cb_neg, next_cb_last, next_cfg_err;
  logic [5:0] next_cb_row;
  logic [6:0] next_cb_col, next_cb_modulus, next_cb_phase;

  // Set choice by floor(log2 N) and Hadamard size by ceil(log2 N)
  logic [2:0] req_set;
  logic [6:0] req_had;
  always_comb begin
    req_set = 3'(BCF_NSETS - 1);
    for (int i = BCF_NSETS - 2; i >= 0; i--) begin
      if (cfg_ant_count <= BCF_SET_NMAX[i]) begin
        req_set = 3'(i);
      end
    end
    req_had = BCF_HAD_MIN;
    for (int i = 0; i < BCF_HAD_STEPS - 1; i++) begin
      if ({1'b0, cfg_ant_count} > req_had) begin
        req_had = 7'(req_had << 1);
      end
    end
  end

  // Step along a row is (r_n - 1); table read needs no multiplier
  logic [6:0] ds_row;
  logic [6:0] step;
  logic [7:0] acc_sum;
  logic [6:0] acc_wrap;
  logic had_neg;
  always_comb begin
    ds_row = BCF_DS[7'(BCF_SET_BASE[set_idx] + {1'b0, row})];
    step = 7'(ds_row - 7'h01);
    acc_sum = {1'b0, acc} + {1'b0, step};
    acc_wrap = (acc_sum >= {1'b0, modulus}) ? 7'(acc_sum - {1'b0, modulus}) : acc_sum[6:0];
    // Sylvester sign; H(32) kron H(2) gives the same parity rule at size 64
    had_neg = ^({1'b0, row} & col);
  end

  // Codebook walk: rows outer, columns inner
  always_comb begin
    next_state = state;
    next_book = book;
    next_nant = nant;
    next_set_idx = set_idx;
    next_modulus = modulus;
    next_last_col = last_col;
    next_row = row;
    next_col = col;
    next_acc = acc;
    next_cb_valid = 1'b0;
    next_cb_row = cb_row;
    next_cb_col = cb_col;
    next_cb_modulus = cb_modulus;
    next_cb_phase = cb_phase;
    next_cb_neg = cb_neg;
    next_cb_last = 1'b0;
    next_cfg_err = 1'b0;
    unique case (state)
      BCF_IDLE: begin
        if (cb_start) begin
          // Counts outside 2..36 have no table entry and are refused
          if (cfg_ant_count < BCF_ANT_MIN || cfg_ant_count > BCF_ANT_MAX) begin
            next_cfg_err = 1'b1;
          end else begin
            next_state = BCF_RUN;
            next_book = cb_book;
            next_nant = cfg_ant_count;
            next_set_idx = req_set;
            next_modulus = (cb_book == BCF_BOOK_FOURIER) ? BCF_SET_MOD[req_set] : req_had;
            next_last_col = (cb_book == BCF_BOOK_FOURIER) ? 7'(BCF_SET_MOD[req_set] - 7'h01)
                                                          : 7'(req_had - 7'h01);
            next_row = 6'h00;
            next_col = 7'h00;
            next_acc = 7'h00;
          end
        end
      end
      BCF_RUN: begin
        next_cb_valid = 1'b1;
        next_cb_row = row;
        next_cb_col = col;
        next_cb_modulus = modulus;
        next_cb_phase = (book == BCF_BOOK_FOURIER) ? acc : 7'h00;
        next_cb_neg = (book == BCF_BOOK_HADAMARD) ? had_neg : 1'b0;
        if (col == last_col) begin
          next_col = 7'h00;
          next_acc = 7'h00;
          next_row = 6'(row + 6'h01);
          if (row == 6'(nant - 6'h01)) begin
            next_cb_last = 1'b1;
            next_state = BCF_IDLE;
          end
        end else begin
          next_col = 7'(col + 7'h01);
          next_acc = acc_wrap;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= BCF_IDLE;
      book <= BCF_BOOK_FOURIER;
      nant <= BCF_ANT_MIN;
      set_idx <= 3'h0;
      modulus <= 7'h00;
      last_col <= 7'h00;
      row <= 6'h00;
      col <= 7'h00;
      acc <= 7'h00;
      cb_valid <= 1'b0;
      cb_row <= 6'h00;
      cb_col <= 7'h00;
      cb_modulus <= 7'h00;
      cb_phase <= 7'h00;
      cb_neg <= 1'b0;
      cb_last <= 1'b0;
      cb_busy <= 1'b0;
      cfg_err <= 1'b0;
    end else begin
      state <= next_state;
      book <= next_book;
      nant <= next_nant;
      set_idx <= next_set_idx;
      modulus <= next_modulus;
      last_col <= next_last_col;
      row <= next_row;
      col <= next_col;
      acc <= next_acc;
      cb_valid <= next_cb_valid;
      cb_row <= next_cb_row;
      cb_col <= next_cb_col;
      cb_modulus <= next_cb_modulus;
      cb_phase <= next_cb_phase;
      cb_neg <= next_cb_neg;
      cb_last <= next_cb_last;
      cb_busy <= (next_state == BCF_RUN);
      cfg_err <= next_cfg_err;
    end
  end

  // Quantiser: offset by half a step so a floor gives round-to-nearest
  logic signed [BCF_PH_W:0] ph_off;
  logic [BCF_NQ-1:1] ph_ge;
  // Signed widen first; an unsigned concatenation would turn the compares unsigned
  assign ph_off = (BCF_PH_W + 1)'(wt_phase) - BCF_PH_LO;
  genvar gk;
  generate
    for (gk = 1; gk < BCF_NQ; gk++) begin : g_thr
      assign ph_ge[gk] = (ph_off >= (BCF_PH_STEP * gk));
    end
  endgenerate

  logic [3:0] q_idx;
  logic q_bad;
  logic [5:0] comp, next_comp;
  logic next_fb_valid, next_fb_last, next_fb_err;
  logic [7:0] next_fb_octet;
  logic [5:0] next_fb_comp;
  always_comb begin
    q_idx = 4'h0;
    for (int i = 1; i < BCF_NQ; i++) begin
      q_idx = 4'(q_idx + {3'h0, ph_ge[i]});
    end
    // Out-of-range phase is flagged; index saturates at the ends
    q_bad = (wt_phase < BCF_PH_LO) || (wt_phase >= BCF_PH_HI);
    next_comp = comp;
    next_fb_valid = wt_valid;
    next_fb_octet = fb_octet;
    next_fb_comp = fb_comp;
    next_fb_last = 1'b0;
    next_fb_err = 1'b0;
    if (wt_valid) begin
      next_fb_octet = {BCF_RSV_BITS, q_idx};
      next_fb_comp = comp;
      next_fb_err = q_bad;
      // Components counted upward, wrapping after N for the next vector
      if (comp >= 6'(cfg_ant_count - 6'h01)) begin
        next_fb_last = 1'b1;
        next_comp = 6'h00;
      end else begin
        next_comp = 6'(comp + 6'h01);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      comp <= 6'h00;
      fb_valid <= 1'b0;
      fb_octet <= 8'h00;
      fb_comp <= 6'h00;
      fb_last <= 1'b0;
      fb_range_err <= 1'b0;
    end else begin
      comp <= next_comp;
      fb_valid <= next_fb_valid;
      fb_octet <= next_fb_octet;
      fb_comp <= next_fb_comp;
      fb_last <= next_fb_last;
      fb_range_err <= next_fb_err;
    end
  end

endmodule

`default_nettype wire

//--- hdl/bcf_pkg.sv
package bcf_pkg;

  // Antenna count limits and table sizes
  localparam logic [5:0] BCF_ANT_MIN = 6'h02;
  localparam logic [5:0] BCF_ANT_MAX = 6'h24;
  localparam int BCF_NSETS = 5;
  localparam int BCF_DS_LEN = 119;
  localparam int BCF_HAD_STEPS = 6;
  localparam logic [6:0] BCF_HAD_MIN = 7'h02;

  // Codebook family
  typedef enum logic {BCF_BOOK_FOURIER, BCF_BOOK_HADAMARD} bcf_book_e;
  typedef enum logic {BCF_IDLE, BCF_RUN} bcf_state_e;

  // Largest antenna count of each Fourier set; N above the last falls in set 4
  localparam logic [5:0] BCF_SET_NMAX [0:3] = '{6'h03, 6'h07, 6'h0f, 6'h1f};
  // Modulus M and table base per set
  localparam logic [6:0] BCF_SET_MOD [0:4] = '{7'h07, 7'h0f, 7'h1f, 7'h3f, 7'h7f};
  localparam logic [6:0] BCF_SET_BASE [0:4] = '{7'h00, 7'h03, 7'h0a, 7'h19, 7'h38};

  // Modulo-M difference sets, all five concatenated, one-based row numbers
  localparam logic [6:0] BCF_DS [0:BCF_DS_LEN-1] = '{
    7'h02, 7'h03, 7'h05,
    7'h01, 7'h06, 7'h08, 7'h0b, 7'h0c, 7'h0e, 7'h0f,
    7'h02, 7'h03, 7'h04, 7'h05, 7'h07, 7'h09, 7'h0d, 7'h10, 7'h11, 7'h12, 7'h18, 7'h19,
    7'h1c, 7'h1e, 7'h1f,
    7'h01, 7'h08, 7'h0a, 7'h0c, 7'h0f, 7'h10, 7'h13, 7'h17, 7'h1a, 7'h1c, 7'h1d, 7'h1f,
    7'h20, 7'h24, 7'h25, 7'h26, 7'h28, 7'h2d, 7'h2e, 7'h30, 7'h32, 7'h33, 7'h34, 7'h37,
    7'h38, 7'h39, 7'h3b, 7'h3c, 7'h3d, 7'h3e, 7'h3f,
    7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h10,
    7'h11, 7'h12, 7'h13, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1e, 7'h1f, 7'h21, 7'h22, 7'h23,
    7'h25, 7'h28, 7'h29, 7'h2d, 7'h2f, 7'h31, 7'h32, 7'h38, 7'h3a, 7'h3b, 7'h3c, 7'h3d,
    7'h41, 7'h42, 7'h43, 7'h45, 7'h46, 7'h48, 7'h49, 7'h4c, 7'h4f, 7'h51, 7'h54, 7'h59,
    7'h5c, 7'h5d, 7'h5e, 7'h61, 7'h63, 7'h64, 7'h66, 7'h6a, 7'h6e, 7'h6f, 7'h72, 7'h73,
    7'h75, 7'h77, 7'h79
  };

  // Phase in sixteenths of a degree, signed
  localparam int BCF_PH_W = 14;
  localparam logic signed [BCF_PH_W:0] BCF_PH_LO = -15'sh00b4;  // -11.25 deg
  localparam logic signed [BCF_PH_W:0] BCF_PH_HI = 15'sh15cc;   // 348.75 deg, excluded
  localparam logic signed [BCF_PH_W:0] BCF_PH_STEP = 15'sh0168; // 22.5 deg
  localparam int BCF_NQ = 16;
  localparam logic [3:0] BCF_RSV_BITS = 4'h0;

endpackage

//--- verification/bcf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcf_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Codebook side
  input wire logic cb_start,
  input wire logic [5:0] cfg_ant_count,
  input wire logic cb_valid,
  input wire logic [5:0] cb_row,
  input wire logic [6:0] cb_col,
  input wire logic [6:0] cb_modulus,
  input wire logic [6:0] cb_phase,
  input wire logic cb_neg,
  input wire logic cb_last,
  input wire logic cb_busy,
  input wire logic cfg_err,
  // Feedback side
  input wire logic wt_valid,
  input wire logic signed [13:0] wt_phase,
  input wire logic fb_valid,
  input wire logic [7:0] fb_octet,
  input wire logic [5:0] fb_comp,
  input wire logic fb_last,
  input wire logic fb_range_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // A start only counts in idle; busy covers the walk's last state too
  sequence s_take;
    cb_start && !cb_busy;
  endsequence
  sequence s_first;
    ##2 cb_valid && cb_row == 6'h00 && cb_col == 7'h00;
  endsequence
  wire n_ok = cfg_ant_count >= 6'h02 && cfg_ant_count <= 6'h24;
  cb_first_a: assert property (s_take ##0 n_ok |-> s_first)
    else $error("walk did not open at element 0");
  cb_err_a: assert property (s_take ##0 !n_ok |=> cfg_err ##1 !cb_valid)
    else $error("bad antenna count not refused");
  cb_step_a: assert property (cb_valid && !cb_last && cb_col != cb_modulus - 7'h01 |=>
    cb_valid && cb_col == $past(cb_col) + 7'h01 && cb_row == $past(cb_row))
    else $error("column did not advance");
  cb_wrap_a: assert property (cb_valid && !cb_last && cb_col == cb_modulus - 7'h01 |=>
    cb_valid && cb_col == 7'h00 && cb_row == $past(cb_row) + 6'h01)
    else $error("row did not advance");
  cb_range_a: assert property (cb_valid |-> cb_col < cb_modulus && cb_phase < cb_modulus)
    else $error("element outside modulus");
  cb_sign_a: assert property (cb_valid && cb_neg |-> cb_phase == 7'h00)
    else $error("sign on a phase element");
  fb_lat_a: assert property (wt_valid |=> fb_valid && fb_octet[7:4] == 4'h0)
    else $error("octet late or upper bits set");
  fb_idx_a: assert property (wt_valid && wt_phase >= -14'sd180 && wt_phase < 14'sd5580 |=>
    !fb_range_err && fb_octet[3:0] == 4'(($past(wt_phase) + 14'sd180) / 14'sd360))
    else $error("phase index wrong");
  fb_err_a: assert property (wt_valid && (wt_phase < -14'sd180 || wt_phase >= 14'sd5580) |=> fb_range_err)
    else $error("out of range phase not flagged");
  fb_order_a: assert property (fb_valid && !fb_last ##1 fb_valid |-> fb_comp == $past(fb_comp) + 6'h01)
    else $error("component order broken");
  fb_last_a: assert property (fb_valid |-> fb_last == (fb_comp == cfg_ant_count - 6'h01))
    else $error("last flag misplaced");
endmodule
`default_nettype wire

//--- verification/bcf_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcf_peer_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Feedback octets
  input wire logic fb_valid,
  input wire logic fb_last,
  // Vectors applied so far
  output logic [7:0] applied
);
  logic [7:0] next_applied;
  // Codeword applied on a whole vector only, never a partial one
  always_comb begin
    next_applied = applied;
    if (fb_valid && fb_last) next_applied = applied + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) applied <= 8'h00;
    else applied <= next_applied;
  end
endmodule
`default_nettype wire

//--- verification/tb_beamforming_codebook_feedback.sv
`timescale 1ns/1ps
`default_nettype none
module tb_beamforming_codebook_feedback;
  import bcf_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, cb_start = 1'b0, wt_valid = 1'b0;
  bcf_book_e cb_book = BCF_BOOK_FOURIER;
  logic [5:0] cfg_ant_count = 6'h02;
  logic signed [13:0] wt_phase = 14'sh0000;
  logic cb_valid, cb_neg, cb_last, cb_busy, cfg_err, fb_valid, fb_last, fb_range_err;
  logic [5:0] cb_row, fb_comp;
  logic [6:0] cb_col, cb_modulus, cb_phase;
  logic [7:0] fb_octet, applied;
  int mismatches = 0, tests_run = 0;
  // 20 MHz core clock
  always #25 core_clk = ~core_clk;
  bcf_codebook_feedback u_dut (.core_clk, .rstn, .cb_start, .cb_book, .cfg_ant_count, .cb_valid, .cb_row,
    .cb_col, .cb_modulus, .cb_phase, .cb_neg, .cb_last, .cb_busy, .cfg_err, .wt_valid, .wt_phase,
    .fb_valid, .fb_octet, .fb_comp, .fb_last, .fb_range_err);
  bcf_peer_model u_peer (.core_clk, .rstn, .fb_valid, .fb_last, .applied);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One walk; first two row steps by hand, later rows from the shared set table
  task automatic walk(input bcf_book_e bk, input logic [5:0] n, input logic [6:0] md, input int r0, input int r1);
    int cnt, t, rr, c, r, bs;
    cnt = 0;
    t = 0;
    rr = 0;
    bs = 0;
    for (int k = 0; k < BCF_NSETS; k++) begin
      if (BCF_SET_MOD[k] == md) bs = BCF_SET_BASE[k];
    end
    @(posedge core_clk);
    cb_book <= bk;
    cfg_ant_count <= n;
    cb_start <= 1'b1;
    @(posedge core_clk);
    cb_start <= 1'b0;
    while (cnt < n * md && t < 5000) begin
      @(posedge core_clk);
      #1;
      t++;
      if (cb_valid === 1'b1) begin
        r = cnt / md;
        c = cnt % md;
        if (c == 1) rr = (r == 0) ? r0 : (r == 1) ? r1 : int'(BCF_DS[bs + r]) - 1;
        chk({cb_row, cb_col, cb_modulus, cb_last, cb_busy},
          {6'(r), 7'(c), md, cnt == n * md - 1, cnt != n * md - 1});
        if (bk == BCF_BOOK_FOURIER) chk({cb_phase, cb_neg}, {7'((rr * c) % md), 1'b0});
        else chk({cb_phase, cb_neg}, {7'h00, ^(6'(r) & 6'(c))});
        cnt++;
      end
    end
    chk({cnt, cb_busy}, {int'(n) * int'(md), 1'b0});
  endtask
  // Refused count: one error pulse and no walk behind it
  task automatic bad_n(input logic [5:0] n);
    @(posedge core_clk);
    cfg_ant_count <= n;
    cb_start <= 1'b1;
    @(posedge core_clk);
    cb_start <= 1'b0;
    #1;
    chk(cfg_err, 1'b1);
    repeat (3) begin
      @(posedge core_clk);
      #1;
      chk({cfg_err, cb_valid, cb_busy}, 3'h0);
    end
  endtask
  // Two vectors back to back, rounding edges and both range limits
  task automatic feed;
    logic signed [13:0] ph [0:7];
    int k, idx;
    logic e;
    ph = '{-14'sd180, 14'sd179, 14'sd180, 14'sd5579, 14'sd5580, -14'sd181, 14'sd0, 14'sd900};
    @(posedge core_clk);
    cfg_ant_count <= 6'h04;
    for (k = 0; k <= 8; k++) begin
      @(posedge core_clk);
      wt_valid <= (k < 8);
      wt_phase <= ph[k % 8];
      #1;
      if (k > 0) begin
        e = ph[k-1] < -14'sd180 || ph[k-1] >= 14'sd5580;
        idx = e ? (ph[k-1] < 0 ? 0 : 15) : (ph[k-1] + 180) / 360;
        chk({fb_valid, fb_octet, fb_comp, fb_last, fb_range_err},
          {1'b1, 4'h0, 4'(idx), 6'((k - 1) % 4), (k - 1) % 4 == 3, e});
      end
    end
    @(posedge core_clk);
    #1;
    chk(applied, 8'h02);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    walk(BCF_BOOK_FOURIER, 6'h02, 7'h07, 1, 2);
    walk(BCF_BOOK_FOURIER, 6'h04, 7'h0f, 0, 5);
    walk(BCF_BOOK_FOURIER, 6'h08, 7'h1f, 1, 2);
    walk(BCF_BOOK_FOURIER, 6'h10, 7'h3f, 0, 7);
    walk(BCF_BOOK_FOURIER, 6'h20, 7'h7f, 1, 2);
    walk(BCF_BOOK_FOURIER, 6'h24, 7'h7f, 1, 2);
    walk(BCF_BOOK_HADAMARD, 6'h03, 7'h04, 0, 0);
    walk(BCF_BOOK_HADAMARD, 6'h09, 7'h10, 0, 0);
    walk(BCF_BOOK_HADAMARD, 6'h24, 7'h40, 0, 0);
    bad_n(6'h01);
    bad_n(6'h25);
    feed;
    give_verdict;
  end
  // Watchdog, well past the roughly 12500 cycles the run needs
  initial begin
    #(50 * 30000);
    mismatches++;
    give_verdict;
  end
endmodule
bind bcf_codebook_feedback bcf_monitor u_mon (.core_clk, .rstn, .cb_start, .cfg_ant_count, .cb_valid, .cb_row,
  .cb_col, .cb_modulus, .cb_phase, .cb_neg, .cb_last, .cb_busy, .cfg_err, .wt_valid, .wt_phase, .fb_valid,
  .fb_octet, .fb_comp, .fb_last, .fb_range_err);
`default_nettype wire
